// File: logic/mic_pkg.sv
// Purpose: shared constants and types for the interrupt controller
// Assumes: apb slave, 32-bit data, one word per register
// Notes:   register offsets are byte addresses
package mic_pkg;
    localparam logic [7:0] MIC_OFS_REQ1   = 8'h00;
    localparam logic [7:0] MIC_OFS_REQ2   = 8'h04;
    localparam logic [7:0] MIC_OFS_WAKE   = 8'h08;
    localparam logic [7:0] MIC_OFS_EN1    = 8'h0c;
    localparam logic [7:0] MIC_OFS_EN2    = 8'h10;
    localparam logic [7:0] MIC_OFS_EDGE   = 8'h14;
    localparam logic [7:0] MIC_OFS_PMODE  = 8'h18;
    localparam logic [7:0] MIC_OFS_CTRL   = 8'h1c;
    localparam logic [7:0] MIC_OFS_VEC    = 8'h20;

    localparam int MIC_NIRQ  = 5;
    localparam int MIC_NWAKE = 8;
    localparam int MIC_NSRC  = 32;

    // request register 1 layout
    localparam int MIC_B1_TMR_A   = 7;
    localparam int MIC_B1_SER1    = 6;
    localparam int MIC_B1_RSVD    = 5;
    // request register 2 layout
    localparam int MIC_B2_DIRECT  = 7;
    localparam int MIC_B2_ADC     = 6;
    localparam int MIC_B2_SER2    = 5;
    localparam int MIC_B2_TMR_G   = 4;
    localparam int MIC_B2_TMR_FH  = 3;
    localparam int MIC_B2_TMR_FL  = 2;
    localparam int MIC_B2_TMR_C   = 1;
    localparam int MIC_B2_TMR_B   = 0;
    // enable register 1: wakeup shared enable
    localparam int MIC_E1_WAKE    = 5;
    // control register: global mask bit
    localparam int MIC_CTRL_MASK  = 0;

    localparam logic [7:0] MIC_REQ1_RST = 8'h20;
    localparam logic [7:0] MIC_ZERO8    = 8'h00;
    localparam logic [4:0] MIC_VEC_IRQ0 = 5'h04;
    localparam logic [4:0] MIC_VEC_WAKE = 5'h09;
    localparam logic [4:0] MIC_VEC_INT0 = 5'h0a;
    localparam logic [4:0] MIC_VEC_MAX  = 5'h14;
    localparam logic [31:0] MIC_BAD_RD  = 32'h0000_0000;

    // strobes from timers and peripherals, one cycle each
    typedef struct packed {
        logic tmr_a_ovf;
        logic ser1_done;
        logic direct_xfer;
        logic adc_done;
        logic ser2_done;
        logic tmr_g_edge;
        logic tmr_c_up_wrap;
        logic tmr_c_dn_wrap;
        logic tmr_b_ovf;
    } mic_events_t;

    // timer f compare state
    typedef struct packed {
        logic       mode16;
        logic [7:0] counter_f_low;
        logic [7:0] counter_f_high;
        logic [7:0] compare_f_low;
        logic [7:0] compare_f_high;
    } mic_tmr_f_t;

    typedef struct packed {
        logic       take;
        logic [4:0] vec;
    } mic_accept_t;
endpackage

// File: logic/mic_edge_det.sv
// Purpose: synchronous edge detector for external interrupt pins
// Assumes: pins already synchronous to clk
// Notes:   one pulse per transition of the selected polarity while the pin function is selected
`timescale 1ns/100ps
module mic_edge_det #(
    parameter int N = 8
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [N-1:0] pin,
    input  wire logic [N-1:0] sel,
    input  wire logic [N-1:0] rising,
    output logic      [N-1:0] hit
);
    typedef struct packed {
        logic [N-1:0] prev;
    } mic_ed_state_t;

    mic_ed_state_t s_reg;
    mic_ed_state_t s_next;

    always_comb begin
        s_next.prev = pin;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    // reset prev high so a high pin at release is not seen as a rise
    always_comb begin
        for (int i = 0; i < N; i++) begin
            hit[i] = sel[i] && (rising[i] ? (pin[i] && !s_reg.prev[i])
                                          : (!pin[i] && s_reg.prev[i]));
        end
    end
endmodule

// File: logic/mic_ctrl.sv
// Purpose: interrupt controller: request flags, enables, priority, acceptance
// Assumes: apb slave with one wait state; core handshake on accept/ack
// Notes:   unmapped reads return zero, unmapped writes are dropped
// Function
// - flags cleared only by writing zero
// - timer g capture edge sets bit 4
// - timer f high match sets bit 3
// - timer f low match sets bit 2
// - timer c wrap either way sets bit 1
// - timer b overflow sets bit 0
// - wakeup flags set on enabled falling edge
// - thirteen external sources, eight wakeup five edge
// - wakeup shared enable and mask gate requests
// - all wakeup pins share vector nine
// - per-pin edge polarity select
// - edge flag needs pin mode select
// - per-input edge interrupt enables
// - edge inputs vectors four to eight
// - internal sources use vectors ten to nineteen
// - enabled condition sets request flag
// - highest priority pending request selected
// - core stacks pc and condition code
// - acceptance sets global mask bit
// - vector number handed to core for fetch
// - clear colliding with request still serviced
// - direct, adc, serial two flags bits 7..5
// - enables reset to zero
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module mic_ctrl
    import mic_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [31:0]               prdata,
    input  wire logic [MIC_NIRQ-1:0]  edge_irq_pin_n,
    input  wire logic [MIC_NWAKE-1:0] wakeup_pin_n,
    input  wire mic_events_t          events,
    input  wire mic_tmr_f_t           tmr_f,
    input  wire logic                 core_ack,
    output logic                      irq_req,
    output logic [4:0]                irq_vector,
    output logic                      mask_bit
);
    typedef struct packed {
        logic [7:0]  request_flags_first;
        logic [7:0]  request_flags_second;
        logic [7:0]  wakeup_request_flags;
        logic [7:0]  enable_reg_first;
        logic [7:0]  enable_reg_second;
        logic [7:0]  edge_select_reg;
        logic [15:0] pin_mode;
        logic        mask;
        logic        req;
        logic [4:0]  vec;
        logic        ready;
        logic        err;
        logic [31:0] rdata;
        logic [7:0]  fl_prev;
        logic [15:0] f16_prev;
    } mic_state_t;

    mic_state_t s_reg;
    mic_state_t s_next;

    logic [MIC_NIRQ-1:0]  irq_hit;
    logic [MIC_NWAKE-1:0] wake_hit;

    // pin mode: low byte selects edge pins, high byte wakeup pins
    mic_edge_det #(.N(MIC_NIRQ)) u_irq_edge (
        .clk    (clk),
        .rstn   (rstn),
        .pin    (edge_irq_pin_n),
        .sel    (s_reg.pin_mode[MIC_NIRQ-1:0]),
        .rising (s_reg.edge_select_reg[MIC_NIRQ-1:0]),
        .hit    (irq_hit)
    );

    mic_edge_det #(.N(MIC_NWAKE)) u_wake_edge (
        .clk    (clk),
        .rstn   (rstn),
        .pin    (wakeup_pin_n),
        .sel    (s_reg.pin_mode[15:8]),
        .rising ({MIC_NWAKE{1'b0}}),
        .hit    (wake_hit)
    );

    // write-zero clears, write-one keeps; set wins over clear
    function automatic logic [7:0] flag_upd(input logic [7:0] cur,
                                            input logic        wr,
                                            input logic [7:0]  wd,
                                            input logic [7:0]  set);
        logic [7:0] kept;
        kept = wr ? (cur & wd) : cur;
        return kept | set;
    endfunction

    // returns lowest vector among pending sources, zero when none
    function automatic mic_accept_t pick(input logic [MIC_NSRC-1:0] pend);
        mic_accept_t r;
        r.take = 1'b0;
        r.vec  = 5'h00;
        for (int v = MIC_NSRC - 1; v >= 0; v--) begin
            if (pend[v]) begin
                r.take = 1'b1;
                r.vec  = v[4:0];
            end
        end
        return r;
    endfunction

    logic        wr_acc;
    logic        rd_acc;
    logic [7:0]  set1;
    logic [7:0]  set2;
    logic        fh_hit;
    logic        fl_hit;
    logic [31:0] pend;
    mic_accept_t sel;
    logic [7:0]  cur_f16_lo;

    always_comb begin
        s_next = s_reg;
        wr_acc = psel && penable && pwrite && !s_reg.ready;
        rd_acc = psel && !penable;
        cur_f16_lo = tmr_f.counter_f_low;

        // timer f compare: edge of match so a held match sets once
        fl_hit = !tmr_f.mode16 && (tmr_f.counter_f_low == tmr_f.compare_f_low)
                 && (s_reg.fl_prev != tmr_f.counter_f_low);
        fh_hit = tmr_f.mode16
                 ? ({tmr_f.counter_f_high, cur_f16_lo}
                    == {tmr_f.compare_f_high, tmr_f.compare_f_low}
                    && s_reg.f16_prev != {tmr_f.counter_f_high, cur_f16_lo})
                 : (tmr_f.counter_f_high == tmr_f.compare_f_high
                    && s_reg.f16_prev[15:8] != tmr_f.counter_f_high);
        s_next.fl_prev  = tmr_f.counter_f_low;
        s_next.f16_prev = {tmr_f.counter_f_high, cur_f16_lo};

        set1 = MIC_ZERO8;
        set1[MIC_NIRQ-1:0] = irq_hit;
        set1[MIC_B1_TMR_A] = events.tmr_a_ovf;
        set1[MIC_B1_SER1]  = events.ser1_done;
        set2 = MIC_ZERO8;
        set2[MIC_B2_DIRECT] = events.direct_xfer;
        set2[MIC_B2_ADC]    = events.adc_done;
        set2[MIC_B2_SER2]   = events.ser2_done;
        set2[MIC_B2_TMR_G]  = events.tmr_g_edge;
        set2[MIC_B2_TMR_FH] = fh_hit;
        set2[MIC_B2_TMR_FL] = fl_hit;
        set2[MIC_B2_TMR_C]  = events.tmr_c_up_wrap || events.tmr_c_dn_wrap;
        set2[MIC_B2_TMR_B]  = events.tmr_b_ovf;

        // flags record every condition; enables gate the request path
        s_next.request_flags_first = flag_upd(s_reg.request_flags_first,
            wr_acc && paddr == MIC_OFS_REQ1, pwdata[7:0], set1);
        s_next.request_flags_first[MIC_B1_RSVD] = 1'b1;
        s_next.request_flags_second = flag_upd(s_reg.request_flags_second,
            wr_acc && paddr == MIC_OFS_REQ2, pwdata[7:0], set2);
        s_next.wakeup_request_flags = flag_upd(s_reg.wakeup_request_flags,
            wr_acc && paddr == MIC_OFS_WAKE, pwdata[7:0], wake_hit);

        // vector map: 4..8 edge, 9 wakeup, 10.. internal
        pend = 32'h0000_0000;
        for (int i = 0; i < MIC_NIRQ; i++) begin
            pend[int'(MIC_VEC_IRQ0) + i] = s_reg.request_flags_first[i]
                                           && s_reg.enable_reg_first[i];
        end
        pend[MIC_VEC_WAKE] = (|s_reg.wakeup_request_flags)
                             && s_reg.enable_reg_first[MIC_E1_WAKE];
        pend[MIC_VEC_INT0]     = s_reg.request_flags_first[MIC_B1_TMR_A]
                                 && s_reg.enable_reg_first[MIC_B1_TMR_A];
        pend[MIC_VEC_INT0 + 1] = s_reg.request_flags_first[MIC_B1_SER1]
                                 && s_reg.enable_reg_first[MIC_B1_SER1];
        for (int i = 0; i < 8; i++) begin
            if (int'(MIC_VEC_INT0) + 9 - i <= int'(MIC_VEC_MAX)) begin
                pend[int'(MIC_VEC_INT0) + 9 - i] = s_reg.request_flags_second[i]
                                                   && s_reg.enable_reg_second[i];
            end
        end
        sel = pick(pend);

        // request held to the core until it acknowledges
        if (s_reg.req) begin
            if (core_ack) begin
                s_next.req  = 1'b0;
                s_next.mask = 1'b1;
            end
        end else if (sel.take && !s_reg.mask) begin
            s_next.req = 1'b1;
            s_next.vec = sel.vec;
        end

        s_next.ready = 1'b0;
        s_next.err   = 1'b0;
        if (psel && penable && !s_reg.ready) begin
            s_next.ready = 1'b1;
        end
        if (wr_acc) begin
            if (paddr == MIC_OFS_EN1) begin
                s_next.enable_reg_first = pwdata[7:0];
            end else if (paddr == MIC_OFS_EN2) begin
                s_next.enable_reg_second = pwdata[7:0];
            end else if (paddr == MIC_OFS_EDGE) begin
                s_next.edge_select_reg = pwdata[7:0];
            end else if (paddr == MIC_OFS_PMODE) begin
                s_next.pin_mode = pwdata[15:0];
            end else if (paddr == MIC_OFS_CTRL) begin
                // software write restores mask; acceptance still wins
                if (!(s_reg.req && core_ack)) begin
                    s_next.mask = pwdata[MIC_CTRL_MASK];
                end
            end else if (paddr == MIC_OFS_REQ1 || paddr == MIC_OFS_REQ2
                         || paddr == MIC_OFS_WAKE || paddr == MIC_OFS_VEC) begin
                s_next.err = 1'b0;
            end else begin
                s_next.err = 1'b1;
            end
        end
        if (rd_acc) begin
            if (paddr == MIC_OFS_REQ1) begin
                s_next.rdata = {24'h000000, s_reg.request_flags_first};
            end else if (paddr == MIC_OFS_REQ2) begin
                s_next.rdata = {24'h000000, s_reg.request_flags_second};
            end else if (paddr == MIC_OFS_WAKE) begin
                s_next.rdata = {24'h000000, s_reg.wakeup_request_flags};
            end else if (paddr == MIC_OFS_EN1) begin
                s_next.rdata = {24'h000000, s_reg.enable_reg_first};
            end else if (paddr == MIC_OFS_EN2) begin
                s_next.rdata = {24'h000000, s_reg.enable_reg_second};
            end else if (paddr == MIC_OFS_EDGE) begin
                s_next.rdata = {24'h000000, s_reg.edge_select_reg};
            end else if (paddr == MIC_OFS_PMODE) begin
                s_next.rdata = {16'h0000, s_reg.pin_mode};
            end else if (paddr == MIC_OFS_CTRL) begin
                s_next.rdata = {31'h0, s_reg.mask};
            end else if (paddr == MIC_OFS_VEC) begin
                s_next.rdata = {26'h0, s_reg.req, s_reg.vec};
            end else begin
                s_next.rdata = MIC_BAD_RD;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.request_flags_first <= MIC_REQ1_RST;
            s_reg.enable_reg_first    <= MIC_ZERO8;
            s_reg.enable_reg_second   <= MIC_ZERO8;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pready     = s_reg.ready;
    assign pslverr    = s_reg.err;
    assign prdata     = s_reg.rdata;
    assign irq_req    = s_reg.req;
    assign irq_vector = s_reg.vec;
    assign mask_bit   = s_reg.mask;
endmodule

// File: tb/mic_core_model.sv
// Purpose: processor core stand-in that takes interrupts from the controller
// Assumes: irq_req is a level held until core_ack
// Notes:   lat sets how many cycles the instruction in flight still needs
`timescale 1ns/100ps
module mic_core_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       irq_req,
    input  wire logic [4:0] irq_vector,
    input  wire logic [3:0] lat,
    output logic            core_ack,
    output logic            taken,
    output logic [4:0]      taken_vec
);
    logic [3:0] cnt;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt       <= 4'h0;
            core_ack  <= 1'b0;
            taken     <= 1'b0;
            taken_vec <= 5'h00;
        end else begin
            core_ack <= 1'b0;
            taken    <= core_ack;
            cnt      <= 4'h0;
            // no second ack while the first one is still being seen
            if (irq_req && !core_ack) begin
                cnt <= cnt + 4'h1;
                // finish current instruction, then stack pc and condition code
                if (cnt >= lat) begin
                    core_ack  <= 1'b1;
                    taken_vec <= irq_vector;
                end
            end
        end
    end
endmodule

// File: tb/mic_ctrl_assertions.sv
// Purpose: port-level checks of the interrupt controller
// Assumes: apb master keeps the request until pready
// Notes:   bound to every instance of the controller
`timescale 1ns/100ps
module mic_ctrl_chk
    import mic_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rstn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [31:0]          prdata,
    input wire logic [MIC_NIRQ-1:0]  edge_irq_pin_n,
    input wire logic [MIC_NWAKE-1:0] wakeup_pin_n,
    input wire mic_events_t          events,
    input wire mic_tmr_f_t           tmr_f,
    input wire logic                 core_ack,
    input wire logic                 irq_req,
    input wire logic [4:0]           irq_vector,
    input wire logic                 mask_bit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_bad_write: assert property (psel && pready && pwrite && paddr > MIC_OFS_VEC |-> pslverr)
        else $error("unmapped write not refused");
    a_bad_read: assert property (psel && pready && !pwrite && paddr > MIC_OFS_VEC
        |-> prdata == MIC_BAD_RD && !pslverr) else $error("unmapped read not zero");
    a_rsvd_one: assert property (pready && !pwrite && paddr == MIC_OFS_REQ1
        |-> prdata[5] && prdata[31:8] == 24'h0) else $error("reserved bit wrong");
    a_accept_mask: assert property (core_ack && irq_req |=> mask_bit && !irq_req)
        else $error("accept did not mask");
    a_masked_hold: assert property ($rose(irq_req) |-> !$past(mask_bit))
        else $error("request raised while masked");
    a_req_holds: assert property (irq_req && !core_ack |=> irq_req)
        else $error("request dropped before ack");
    a_vec_range: assert property (irq_req
        |-> irq_vector >= MIC_VEC_IRQ0 && irq_vector <= MIC_VEC_MAX)
        else $error("vector out of range");
endmodule

bind mic_ctrl mic_ctrl_chk i_mic_ctrl_chk (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .edge_irq_pin_n(edge_irq_pin_n), .wakeup_pin_n(wakeup_pin_n), .events(events),
    .tmr_f(tmr_f), .core_ack(core_ack), .irq_req(irq_req), .irq_vector(irq_vector),
    .mask_bit(mask_bit)
);

// File: tb/mic_ctrl_tb_top.sv
// Purpose: directed tests of the interrupt controller over apb
// Assumes: core model answers every request
// Notes:   pins idle high so pin mode switches raise no flag
`timescale 1ns/100ps
module mic_ctrl_tb_top
    import mic_pkg::*;
;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic        core_ack, irq_req, mask_bit, taken;
    logic [7:0]  paddr, adr, wakeup_pin_n;
    logic [31:0] pwdata, prdata, rd, base;
    logic [4:0]  edge_irq_pin_n, irq_vector, taken_vec;
    logic [3:0]  lat;
    mic_events_t events;
    mic_tmr_f_t  tmr_f;
    int          mismatches, n_tests;
    logic [31:0] evx [9] = '{32'h01, 32'h02, 32'h02, 32'h10, 32'h20, 32'h40, 32'h80,
                             32'h40, 32'h80};

    mic_ctrl i_mic_ctrl (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .edge_irq_pin_n(edge_irq_pin_n), .wakeup_pin_n(wakeup_pin_n),
        .events(events), .tmr_f(tmr_f), .core_ack(core_ack), .irq_req(irq_req),
        .irq_vector(irq_vector), .mask_bit(mask_bit));
    mic_core_model i_mic_core_model (.clk(clk), .rstn(rstn), .irq_req(irq_req),
        .irq_vector(irq_vector), .lat(lat), .core_ack(core_ack), .taken(taken),
        .taken_vec(taken_vec));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one idle edge first, so psel is never assigned twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic pulse(input mic_events_t e);
        @(posedge clk);
        events <= e;
        @(posedge clk);
        events <= '0;
    endtask

    task automatic pins(input logic [4:0] e, input logic [7:0] w);
        @(posedge clk);
        edge_irq_pin_n <= e;
        wakeup_pin_n <= w;
        repeat (3) @(posedge clk);
    endtask

    task automatic tf(input logic m, input logic [7:0] fl, input logic [7:0] fh);
        @(posedge clk);
        tmr_f.mode16 <= m;
        tmr_f.counter_f_low <= fl;
        tmr_f.counter_f_high <= fh;
        repeat (3) @(posedge clk);
    endtask

    task automatic take(input logic [4:0] v);
        int k;
        k = 0;
        while (taken !== 1'b1 && k < 40) begin
            @(posedge clk);
            k++;
        end
        chk({31'h0, taken}, 32'h1);
        chk({27'h0, taken_vec}, {27'h0, v});
    endtask

    task automatic wrap_up;
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        edge_irq_pin_n = 5'h1f;
        wakeup_pin_n = 8'hff;
        events = '0;
        // compares away from zero so idle counters do not match
        tmr_f = '{1'b0, 8'h00, 8'h00, 8'h55, 8'haa};
        lat = 4'h0;
        mismatches = 0;
        n_tests = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rdchk(MIC_OFS_REQ1, 32'h20);
        rdchk(MIC_OFS_REQ2, 32'h0);
        rdchk(MIC_OFS_WAKE, 32'h0);
        rdchk(MIC_OFS_EN1, 32'h0);
        rdchk(MIC_OFS_EN2, 32'h0);
        apb(1'b1, 8'h40, 32'hff);
        chk({31'h0, err}, 32'h1);
        rdchk(8'h40, 32'h0);
        for (int i = 0; i < 9; i++) begin
            adr = (i < 7) ? MIC_OFS_REQ2 : MIC_OFS_REQ1;
            base = (i < 7) ? 32'h0 : 32'h20;
            pulse(mic_events_t'(9'h1 << i));
            rdchk(adr, base | evx[i]);
            apb(1'b1, adr, 32'hff);
            rdchk(adr, base | evx[i]);
            apb(1'b1, adr, 32'h0);
            rdchk(adr, base);
        end
        tf(1'b0, 8'h55, 8'h00);
        rdchk(MIC_OFS_REQ2, 32'h04);
        tf(1'b0, 8'h55, 8'haa);
        rdchk(MIC_OFS_REQ2, 32'h0c);
        tf(1'b0, 8'h00, 8'h00);
        apb(1'b1, MIC_OFS_REQ2, 32'h0);
        tf(1'b1, 8'h55, 8'haa);
        rdchk(MIC_OFS_REQ2, 32'h08);
        apb(1'b1, MIC_OFS_REQ2, 32'h0);
        pins(5'h1e, 8'hf7);
        pins(5'h1f, 8'hff);
        rdchk(MIC_OFS_REQ1, 32'h20);
        rdchk(MIC_OFS_WAKE, 32'h0);
        apb(1'b1, MIC_OFS_EDGE, 32'h01);
        apb(1'b1, MIC_OFS_PMODE, 32'hff1f);
        pins(5'h1c, 8'hf7);
        pins(5'h1d, 8'hff);
        pins(5'h1f, 8'hff);
        rdchk(MIC_OFS_REQ1, 32'h23);
        rdchk(MIC_OFS_WAKE, 32'h08);
        chk({31'h0, irq_req}, 32'h0);
        apb(1'b1, MIC_OFS_CTRL, 32'h1);
        apb(1'b1, MIC_OFS_EN1, 32'h03);
        // a wrongly raised request shows only after the next edge
        repeat (2) @(posedge clk);
        chk({31'h0, irq_req}, 32'h0);
        apb(1'b1, MIC_OFS_CTRL, 32'h0);
        take(5'h04);
        chk({31'h0, mask_bit}, 32'h1);
        rdchk(MIC_OFS_REQ1, 32'h23);
        apb(1'b1, MIC_OFS_REQ1, 32'h22);
        apb(1'b1, MIC_OFS_CTRL, 32'h0);
        take(5'h05);
        lat <= 4'h6;
        apb(1'b1, MIC_OFS_REQ1, 32'h20);
        apb(1'b1, MIC_OFS_EN1, 32'h20);
        apb(1'b1, MIC_OFS_CTRL, 32'h0);
        take(MIC_VEC_WAKE);
        rdchk(MIC_OFS_WAKE, 32'h08);
        apb(1'b1, MIC_OFS_WAKE, 32'h0);
        apb(1'b1, MIC_OFS_EN2, 32'h01);
        pulse(mic_events_t'(9'h001));
        repeat (3) @(posedge clk);
        chk({31'h0, irq_req}, 32'h0);
        rdchk(MIC_OFS_CTRL, 32'h1);
        apb(1'b1, MIC_OFS_CTRL, 32'h0);
        take(5'h13);
        rdchk(MIC_OFS_VEC, 32'h13);
        wrap_up();
    end
endmodule
